// ===== rsc_pkg.sv
// Constants and types for the reset source and cause logic.
// Assumes a single 25 MHz clock domain and plain-port control bits.
//
// Function
// - Watchdog flag sticky until cleared or hard reset
// - Enabled watchdog expiry issues a watchdog reset
// - Software reset bit write forces full reset
// - Reset control writes need key in top half
// - Soft flag sticky until cleared or hard reset
// - Low pin requests reset, high ignored, pulled up
// - Held in reset while pin low, then boot
// - Power, supply-drop, pin resets set no flag
// - Hold reset at power-up until supply good
// - Supply-drop reset active except in Stop mode
// - Protection violation causes a device reset
// - Protection flag sticky until cleared or hard reset
// - Hibernate pin/comparator wake resets, retains memory
// - Wake interrupt status survives hibernate wake reset
// - Stop mode: pin or wake pin wake reset
// - Stop key survives wake pin, not reset pin
// - Cause bits: watchdog 0, protection 3, soft 4
package rsc_pkg;

  // ==========================================================
  // Cause register layout
  localparam int         CAUSE_W         = 5;
  localparam int         CAUSE_WDT_BIT   = 0;
  localparam int         CAUSE_PROT_BIT  = 3;
  localparam int         CAUSE_SOFT_BIT  = 4;
  localparam logic [4:0] CAUSE_RESET_VAL = 5'h00;

  // ==========================================================
  // Application reset control register
  localparam logic [15:0] ARC_KEY         = 16'hA05F;
  localparam int          ARC_KEY_LSB     = 16;
  localparam int          ARC_SYSREQ_BIT  = 2;

  // ==========================================================
  // Stop key field
  localparam int         STOP_KEY_W       = 8;
  localparam logic [7:0] STOP_KEY_RESET   = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_HZ          = 25000000;
  localparam int HOLD_NS         = 2000;
  localparam int HOLD_CYCLES     = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WDT_W           = 16;
  localparam logic [15:0] WDT_INTERVAL_RESET = 16'hFFFF;

  // ==========================================================
  // Power modes and sequencer states
  typedef enum logic [1:0]
  {
    PM_ACTIVE    = 2'h0,
    PM_HIBERNATE = 2'h1,
    PM_STOP      = 2'h2
  } rsc_pmode_t;

  typedef enum logic [2:0]
  {
    ST_HOLD = 3'h1,
    ST_BOOT = 3'h2,
    ST_RUN  = 3'h4
  } rsc_state_t;

endpackage : rsc_pkg

// ===== rsc_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the destination runs on i_clk; reset value is a parameter.
`timescale 1ns/1ps
module rsc_sync
#(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b0
)
(
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= {W{RST_VAL}};
      o_q    <= {W{RST_VAL}};
    end
    else
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule : rsc_sync

// ===== rsc_top.sv
// Reset source gathering, sequencing and cause flag logic.
// Assumes i_resetn is the raw power-on reset; other sources are pins
// or internal strobes. Cause and stop key state is retention logic
// reset only by power-on, external pin or non-retention drop; cause bits also clear on a write of one.
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_supply_good,
  input  wire logic             i_supply_drop,
  input  wire logic             i_supply_drop_nonret,
  input  wire logic             i_external_reset_pin_n,
  input  wire logic             i_wake_pin,
  input  wire logic             i_hib_pin_irq,
  input  wire logic             i_hib_cmp_irq,
  input  wire logic             i_protection_violation,
  input  wire logic [1:0]       i_power_mode,
  input  wire logic             i_arc_wr,
  input  wire logic [31:0]      i_arc_wdata,
  input  wire logic             i_counter_enable_bit,
  input  wire logic [WDT_W-1:0] i_wdt_interval,
  input  wire logic             i_wdt_clear,
  input  wire logic             i_cause_wr,
  input  wire logic [CAUSE_W-1:0] i_cause_wdata,
  input  wire logic             i_stop_key_wr,
  input  wire logic [STOP_KEY_W-1:0] i_stop_key,
  input  wire logic             i_wake_stat_clr,
  output logic                  o_system_reset_n,
  output logic                  o_retain_memory,
  output logic [CAUSE_W-1:0]    o_reset_cause_register,
  output logic [STOP_KEY_W-1:0] o_stop_key,
  output logic [1:0]            o_wake_irq_status,
  output logic                  o_pullup_en
);

  // ==========================================================
  // Input synchronisers
  logic [6:0] raw_s;
  logic       pin_n_s;
  logic       supply_good_s;
  logic       drop_s;
  logic       drop_nonret_s;
  logic       wake_pin_s;
  logic       hib_pin_s;
  logic       hib_cmp_s;

  rsc_sync #(.W(7), .RST_VAL(1'b0)) u_sync
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({i_external_reset_pin_n, i_supply_good, i_supply_drop,
                i_supply_drop_nonret, i_wake_pin, i_hib_pin_irq, i_hib_cmp_irq}),
    .o_q      (raw_s)
  );

  assign pin_n_s       = raw_s[6];
  assign supply_good_s = raw_s[5];
  assign drop_s        = raw_s[4];
  assign drop_nonret_s = raw_s[3];
  assign wake_pin_s    = raw_s[2];
  assign hib_pin_s     = raw_s[1];
  assign hib_cmp_s     = raw_s[0];

  function automatic logic mode_is(input logic [1:0] m, input rsc_pmode_t p);
    mode_is = (m == p);
  endfunction : mode_is

  logic in_stop;
  logic in_hib;
  assign in_stop = mode_is(i_power_mode, PM_STOP);
  assign in_hib  = mode_is(i_power_mode, PM_HIBERNATE);

  // ==========================================================
  // Reset request decode
  logic       pin_req;
  logic       drop_req;
  logic       nonret_req;
  logic       sw_req;
  logic       wdt_req;
  logic       prot_req;
  logic       hib_wake;
  logic       stop_wake_pin;
  logic       any_req;
  logic       hard_clr;
  logic       running;

  assign pin_req    = !pin_n_s;
  assign drop_req   = drop_s && !in_stop;
  assign nonret_req = drop_nonret_s && !in_stop;
  assign sw_req     = running && i_arc_wr &&
                      (i_arc_wdata[31:ARC_KEY_LSB] == ARC_KEY) &&
                      i_arc_wdata[ARC_SYSREQ_BIT];
  assign prot_req   = running && i_protection_violation;
  assign hib_wake   = in_hib && (hib_pin_s || hib_cmp_s);
  assign stop_wake_pin = in_stop && wake_pin_s;
  assign hard_clr   = pin_req || nonret_req;
  assign any_req    = pin_req || drop_req || nonret_req || sw_req || wdt_req ||
                      prot_req || hib_wake || stop_wake_pin;

  // ==========================================================
  // Watchdog counter
  logic [WDT_W-1:0] wdt_cnt_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      wdt_cnt_q <= '0;
    else if (!running || !i_counter_enable_bit || i_wdt_clear)
      wdt_cnt_q <= '0;
    else if (!wdt_req)
      wdt_cnt_q <= wdt_cnt_q + 16'h0001;
  end

  assign wdt_req = running && i_counter_enable_bit && !i_wdt_clear &&
                   (wdt_cnt_q >= i_wdt_interval);

  // ==========================================================
  // Reset sequencer
  rsc_state_t        state_q;
  logic [7:0]        hold_q;
  logic              retain_q;

  assign running = (state_q == ST_RUN);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= ST_HOLD;
      hold_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_HOLD:
        begin
          hold_q <= '0;
          if (supply_good_s && pin_n_s && !drop_s && !drop_nonret_s)
            state_q <= ST_BOOT;
        end
        ST_BOOT:
        begin
          if (any_req || !supply_good_s)
            state_q <= ST_HOLD;
          else if (hold_q == 8'(HOLD_CYCLES - 1))
            state_q <= ST_RUN;
          else
            hold_q <= hold_q + 8'h01;
        end
        ST_RUN:
        begin
          if (any_req || !supply_good_s)
            state_q <= ST_HOLD;
        end
        default:
          state_q <= ST_HOLD;
      endcase
    end
  end

  // Retention indicator: hibernate wake keeps memory
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      retain_q <= 1'b0;
    else if (running && any_req)
      retain_q <= hib_wake && !hard_clr && !sw_req && !wdt_req && !prot_req;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_system_reset_n <= 1'b0;
    else
      o_system_reset_n <= running && !any_req && supply_good_s;
  end

  assign o_retain_memory = retain_q;

  // ==========================================================
  // Cause flags
  logic [CAUSE_W-1:0] cause_q;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_clr;

  always_comb
  begin
    cause_set = '0;
    cause_set[CAUSE_WDT_BIT]  = wdt_req;
    cause_set[CAUSE_PROT_BIT] = prot_req;
    cause_set[CAUSE_SOFT_BIT] = sw_req;
    cause_clr = (running && i_cause_wr) ? i_cause_wdata : '0;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cause_q <= CAUSE_RESET_VAL;
    else if (hard_clr)
      cause_q <= CAUSE_RESET_VAL;
    else
      cause_q <= (cause_q & ~cause_clr) | cause_set;
  end

  assign o_reset_cause_register = cause_q;

  // ==========================================================
  // Stop key and hibernate wake status
  logic [STOP_KEY_W-1:0] key_q;
  logic [1:0]            wstat_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      key_q <= STOP_KEY_RESET;
    else if (pin_req || nonret_req)
      key_q <= STOP_KEY_RESET;
    else if (i_stop_key_wr)
      key_q <= i_stop_key;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      wstat_q <= 2'h0;
    else if (in_hib && (hib_pin_s || hib_cmp_s))
      wstat_q <= wstat_q | {hib_pin_s, hib_cmp_s};
    else if (running && i_wake_stat_clr)
      wstat_q <= 2'h0;
  end

  assign o_stop_key        = key_q;
  assign o_wake_irq_status = wstat_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_pullup_en <= 1'b1;
    else
      o_pullup_en <= 1'b1;
  end

  // ==========================================================
  // Assertions
  sequence s_sw_request;
    running && i_arc_wr && (i_arc_wdata[31:16] == 16'hA05F) && i_arc_wdata[2];
  endsequence

  a_soft_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_sw_request and !hard_clr) |=> cause_q[4])
    else $error("soft flag not set");

  a_soft_reset_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_sw_request |=> (!o_system_reset_n && (state_q == ST_HOLD)) ##1 !o_system_reset_n)
    else $error("soft request did not reset");

  a_bad_key_ignored: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_arc_wr && (i_arc_wdata[31:16] != 16'hA05F) |-> !sw_req)
    else $error("unkeyed write acted");

  a_wdt_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wdt_req && !hard_clr |=> cause_q[0])
    else $error("watchdog flag not set");

  a_prot_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    prot_req && !hard_clr |=> cause_q[3] && !o_system_reset_n)
    else $error("protection flag not set");

  a_pin_holds: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !pin_n_s |=> !o_system_reset_n && (state_q == ST_HOLD))
    else $error("pin low but out of reset");

  a_pin_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !pin_n_s |=> (cause_q == 5'h00) && (o_stop_key == 8'h00))
    else $error("pin reset left flags");

  a_stop_no_drop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    in_stop |-> !drop_req && !nonret_req)
    else $error("supply drop acted in stop");

  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cause_q[0] && !hard_clr && !(i_cause_wr && running && i_cause_wdata[0])
    |=> cause_q[0])
    else $error("watchdog flag lost");

  a_power_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !supply_good_s |=> !o_system_reset_n)
    else $error("released without good supply");

  sequence s_wdt_expire;
    running && i_counter_enable_bit && !i_wdt_clear && (wdt_cnt_q >= i_wdt_interval);
  endsequence

  sequence s_hib_wake;
    running && in_hib && (hib_pin_s || hib_cmp_s);
  endsequence

  a_wdt_reset_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_wdt_expire |=> !o_system_reset_n && (state_q == ST_HOLD))
    else $error("watchdog expiry did not reset");

  a_prot_reset_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    running && i_protection_violation |=> !o_system_reset_n && (state_q == ST_HOLD))
    else $error("protection fault did not reset");

  a_hold_out_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !running |=> !o_system_reset_n)
    else $error("reset released before run");

  a_drop_resets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    drop_req |=> !o_system_reset_n && (state_q == ST_HOLD))
    else $error("supply drop did not reset");

  a_nonret_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
    nonret_req |=> (cause_q == CAUSE_RESET_VAL) && (o_stop_key == STOP_KEY_RESET))
    else $error("non-retention drop left flags");

  a_drop_keeps_flags: assert property (@(posedge i_clk) disable iff (!i_resetn)
    drop_req && !hard_clr && (cause_set == '0) && (cause_clr == '0)
    |=> cause_q == $past(cause_q))
    else $error("retention drop changed flags");

  a_retain_hib: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_hib_wake and !hard_clr && !sw_req && !wdt_req && !prot_req)
    |=> o_retain_memory && !o_system_reset_n)
    else $error("hibernate wake did not retain");

  a_retain_other: assert property (@(posedge i_clk) disable iff (!i_resetn)
    running && any_req && !hib_wake |=> !o_retain_memory)
    else $error("retention flagged after other reset");

  a_wstat_kept: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(running && i_wake_stat_clr) |=> (o_wake_irq_status & $past(wstat_q)) == $past(wstat_q))
    else $error("wake status lost");

  a_key_wake_pin: assert property (@(posedge i_clk) disable iff (!i_resetn)
    stop_wake_pin && !hard_clr && !i_stop_key_wr |=> o_stop_key == $past(key_q))
    else $error("stop key lost on wake pin");

  a_clear_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
    running && i_cause_wr && i_cause_wdata[CAUSE_WDT_BIT] && !wdt_req
    |=> !cause_q[CAUSE_WDT_BIT])
    else $error("write one did not clear flag");

endmodule : rsc_top

// ===== rsc_fw_model.sv
// Firmware and board reset pin model for the reset source block.
// Assumes the bench calls its tasks; writes last one clock cycle.
`timescale 1ns/1ps
module rsc_fw_model
  import rsc_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_pullup_en,
  output logic               o_arc_wr,
  output logic [31:0]        o_arc_wdata,
  output logic               o_cause_wr,
  output logic [CAUSE_W-1:0] o_cause_wdata,
  output logic               o_pin_n
);
  logic pin_low = 1'b0;
  initial
  begin
    o_arc_wr = 1'b0;
    o_arc_wdata = 32'h0;
    o_cause_wr = 1'b0;
    o_cause_wdata = 5'h00;
  end
  // Released pin rests at the pull-up level
  assign o_pin_n = pin_low ? 1'b0 : i_pullup_en;
  // ====
  // Register writes, data scrambled once released
  task automatic arc_write(input logic [31:0] d);
    @(negedge i_clk);
    o_arc_wr = 1'b1;
    o_arc_wdata = d;
    @(negedge i_clk);
    o_arc_wr = 1'b0;
    o_arc_wdata = ~d;
  endtask : arc_write
  task automatic cause_write(input logic [CAUSE_W-1:0] d);
    @(negedge i_clk);
    o_cause_wr = 1'b1;
    o_cause_wdata = d;
    @(negedge i_clk);
    o_cause_wr = 1'b0;
    o_cause_wdata = ~d;
  endtask : cause_write
  task automatic pin_drive(input logic low);
    @(negedge i_clk);
    pin_low = low;
  endtask : pin_drive
endmodule : rsc_fw_model

// ===== tb_top.sv
// Self-checking bench for the reset source and cause logic.
// Assumes rsc_fw_model stands in for firmware and the reset pin.
`timescale 1ns/1ps
module tb_top;
  import rsc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, sgood = 1'b0, sdrop = 1'b0, snr = 1'b0;
  logic wake = 1'b0, hpin = 1'b0, hcmp = 1'b0, prot = 1'b0, wen = 1'b0;
  logic wclr = 1'b0, kwr = 1'b0, sclr = 1'b0;
  logic [1:0]  pm = 2'h0;
  logic [15:0] wint = 16'h0010;
  logic [7:0]  key = 8'h00;
  logic        arc_wr, cwr, pin_n, rst_n, ret, pu;
  logic [31:0] arc_d;
  logic [4:0]  cd, cause;
  logic [7:0]  okey;
  logic [1:0]  wst;
  int          errors = 0;
  int          cmp_count = 0;
  bit          ok;
  always #20 clk = ~clk;
  rsc_top u_rsc_top (.i_clk(clk), .i_resetn(rstn), .i_supply_good(sgood),
    .i_supply_drop(sdrop), .i_supply_drop_nonret(snr), .i_external_reset_pin_n(pin_n),
    .i_wake_pin(wake), .i_hib_pin_irq(hpin), .i_hib_cmp_irq(hcmp),
    .i_protection_violation(prot), .i_power_mode(pm), .i_arc_wr(arc_wr),
    .i_arc_wdata(arc_d), .i_counter_enable_bit(wen), .i_wdt_interval(wint),
    .i_wdt_clear(wclr), .i_cause_wr(cwr), .i_cause_wdata(cd), .i_stop_key_wr(kwr),
    .i_stop_key(key), .i_wake_stat_clr(sclr), .o_system_reset_n(rst_n),
    .o_retain_memory(ret), .o_reset_cause_register(cause), .o_stop_key(okey),
    .o_wake_irq_status(wst), .o_pullup_en(pu));
  rsc_fw_model u_rsc_fw_model (.i_clk(clk), .i_pullup_en(pu), .o_arc_wr(arc_wr),
    .o_arc_wdata(arc_d), .o_cause_wr(cwr), .o_cause_wdata(cd), .o_pin_n(pin_n));
  // ====
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wait_rst(input logic v, input int n, output bit res);
    int k;
    k = 0;
    while (rst_n !== v && k < n)
    begin
      cyc(1);
      k++;
    end
    res = (rst_n === v);
  endtask : wait_rst
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // ====
  // Scenarios
  task automatic t_por;
    cyc(20);
    check(rst_n, 1'b0);
    check({cause, okey, wst, pu}, {5'h00, 8'h00, 2'h0, 1'b1});
    sgood = 1'b1;
    wait_rst(1'b1, 150, ok);
    check(ok, 1'b1);
  endtask : t_por
  task automatic t_soft;
    u_rsc_fw_model.arc_write(32'h12340004);
    cyc(4);
    check({rst_n, cause}, {1'b1, 5'h00});
    u_rsc_fw_model.arc_write({ARC_KEY, 16'h0000});
    cyc(4);
    check({rst_n, cause}, {1'b1, 5'h00});
    u_rsc_fw_model.arc_write(32'hA05F0004);
    cyc(1);
    check({rst_n, cause}, {1'b0, 5'h10});
    wait_rst(1'b1, 150, ok);
    check({ok, cause}, {1'b1, 5'h10});
  endtask : t_soft
  task automatic t_wdt;
    wen = 1'b1;
    wclr = 1'b1;
    cyc(60);
    check(rst_n, 1'b1);
    wclr = 1'b0;
    wait_rst(1'b0, 40, ok);
    check(ok, 1'b1);
    wen = 1'b0;
    check(cause, 5'h11);
    wait_rst(1'b1, 150, ok);
    check({ok, cause}, {1'b1, 5'h11});
  endtask : t_wdt
  task automatic t_prot;
    prot = 1'b1;
    cyc(1);
    prot = 1'b0;
    cyc(1);
    check({rst_n, cause}, {1'b0, 5'h19});
    wait_rst(1'b1, 150, ok);
    check(ok, 1'b1);
    u_rsc_fw_model.cause_write(5'h00);
    cyc(1);
    check(cause, 5'h19);
    u_rsc_fw_model.cause_write(5'h11);
    cyc(1);
    check(cause, 5'h08);
  endtask : t_prot
  task automatic t_drop;
    key = 8'h5A;
    kwr = 1'b1;
    cyc(1);
    kwr = 1'b0;
    pm = PM_STOP;
    sdrop = 1'b1;
    cyc(10);
    check(rst_n, 1'b1);
    pm = PM_ACTIVE;
    wait_rst(1'b0, 10, ok);
    check(ok, 1'b1);
    sdrop = 1'b0;
    wait_rst(1'b1, 150, ok);
    check({ok, cause, okey}, {1'b1, 5'h08, 8'h5A});
  endtask : t_drop
  task automatic t_stop;
    pm = PM_STOP;
    wake = 1'b1;
    wait_rst(1'b0, 10, ok);
    check(ok, 1'b1);
    wake = 1'b0;
    pm = PM_ACTIVE;
    wait_rst(1'b1, 150, ok);
    check({ok, cause, okey}, {1'b1, 5'h08, 8'h5A});
    pm = PM_STOP;
    u_rsc_fw_model.pin_drive(1'b1);
    wait_rst(1'b0, 10, ok);
    check(ok, 1'b1);
    cyc(100);
    check(rst_n, 1'b0);
    pm = PM_ACTIVE;
    u_rsc_fw_model.pin_drive(1'b0);
    wait_rst(1'b1, 150, ok);
    check({ok, cause, okey}, {1'b1, 5'h00, 8'h00});
  endtask : t_stop
  task automatic t_hib(input bit cmp);
    pm = PM_HIBERNATE;
    hpin = !cmp;
    hcmp = cmp;
    wait_rst(1'b0, 10, ok);
    check(ok, 1'b1);
    hpin = 1'b0;
    hcmp = 1'b0;
    pm = PM_ACTIVE;
    wait_rst(1'b1, 150, ok);
    check({ok, ret, wst}, {1'b1, 1'b1, cmp ? 2'h1 : 2'h2});
    sclr = 1'b1;
    cyc(1);
    sclr = 1'b0;
    cyc(1);
    check(wst, 2'h0);
  endtask : t_hib
  task automatic t_nonret;
    wint = 16'h0004;
    key = 8'hC3;
    kwr = 1'b1;
    cyc(1);
    kwr = 1'b0;
    u_rsc_fw_model.arc_write(32'hA05F0004);
    cyc(1);
    check({rst_n, cause, ret}, {1'b0, 5'h10, 1'b0});
    wait_rst(1'b1, 150, ok);
    wen = 1'b1;
    wait_rst(1'b0, 20, ok);
    wen = 1'b0;
    check({ok, cause, okey}, {1'b1, 5'h11, 8'hC3});
    wait_rst(1'b1, 150, ok);
    snr = 1'b1;
    wait_rst(1'b0, 10, ok);
    check({ok, cause, okey}, {1'b1, 5'h00, 8'h00});
    snr = 1'b0;
    wait_rst(1'b1, 150, ok);
    check(ok, 1'b1);
    sgood = 1'b0;
    wait_rst(1'b0, 10, ok);
    check(ok, 1'b1);
    sgood = 1'b1;
    wait_rst(1'b1, 150, ok);
    check(ok, 1'b1);
    rstn = 1'b0;
    cyc(2);
    check({rst_n, cause, okey, wst, ret, pu}, {1'b0, 5'h00, 8'h00, 2'h0, 1'b0, 1'b1});
    rstn = 1'b1;
    wait_rst(1'b1, 150, ok);
    check(ok, 1'b1);
  endtask : t_nonret
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end
  initial
  begin
    cyc(5);
    rstn = 1'b1;
    t_por();
    t_soft();
    t_wdt();
    t_prot();
    t_drop();
    t_stop();
    t_hib(1'b0);
    t_hib(1'b1);
    t_nonret();
    stop_test();
  end
endmodule : tb_top
